// >>> src/ssa_pkg.sv
package ssa_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_MODE   = 8'h00;
  localparam logic [7:0] OFS_WIDTH  = 8'h04;
  localparam logic [7:0] OFS_TRIM   = 8'h08;
  localparam logic [7:0] OFS_RES1   = 8'h0c;
  localparam logic [7:0] OFS_RES2   = 8'h10;
  localparam logic [7:0] OFS_RES3   = 8'h14;
  localparam logic [7:0] OFS_RESAUX = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1c;

  // mode control field positions
  localparam int BIT_AUX_LO  = 0;
  localparam int BIT_AUX_HI  = 1;
  localparam int BIT_RATE    = 7;
  localparam int BIT_DOUBLE  = 9;
  // status field positions
  localparam int BIT_ST_WIN  = 16;
  localparam int BIT_ST_TRIP = 20;

  // widths
  localparam int CNT_W   = 12;
  localparam int WIDTH_W = 10;
  localparam int TRIM_W  = 3;
  localparam int NCH     = 4;

  // values after reset
  localparam logic [1:0]         RST_AUX_SEL = 2'h0;
  localparam logic               RST_RATE    = 1'b0;
  localparam logic               RST_DOUBLE  = 1'b0;
  localparam logic [WIDTH_W-1:0] RST_WIDTH   = 10'h064;
  localparam logic [TRIM_W-1:0]  RST_TRIM    = 3'h0;

  // counts and times
  localparam logic [CNT_W-1:0] CNT_LIMIT   = 12'hfff;
  localparam int               CLK_PS      = 20000;
  localparam int               SYNC_MIN_PS = 50000;
  localparam int               SYNC_MAX_PS = 12500000;
  localparam logic [WIDTH_W-1:0] SYNC_MIN_CYC =
    WIDTH_W'((SYNC_MIN_PS + CLK_PS - 1) / CLK_PS);
  localparam logic [WIDTH_W-1:0] SYNC_MAX_CYC = WIDTH_W'(SYNC_MAX_PS / CLK_PS);
endpackage

// >>> src/ssa_sync2.sv
`timescale 1ns/1ns
// two-stage synchroniser for comparator levels
module ssa_sync2 #(
  parameter int W = 4
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } ssa_sync_st_t;

  ssa_sync_st_t st_r;
  ssa_sync_st_t st_nxt;

  // first stage feeds only the second
  always_comb begin
    st_nxt.s1 = d;
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.s2;
endmodule

// >>> src/ssa_sync_gen.sv
`timescale 1ns/1ns
// ramp reset / conversion start pulse generator
module ssa_sync_gen (
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  input  wire logic                         pwm_period_start,
  input  wire logic                         pwm_half_start,
  input  wire logic                         double_update,
  input  wire logic [ssa_pkg::WIDTH_W-1:0]  sync_pulse_width_setting,
  output logic                              pwm_cycle_sync_pulse
);
  typedef struct packed {
    logic [ssa_pkg::WIDTH_W-1:0] remain;
    logic                        pulse;
  } ssa_gen_st_t;

  ssa_gen_st_t                 st_r;
  ssa_gen_st_t                 st_nxt;
  logic [ssa_pkg::WIDTH_W-1:0] width_clamped;
  logic                        start;

  // keep the pulse inside the supported width range
  always_comb begin
    if (sync_pulse_width_setting < ssa_pkg::SYNC_MIN_CYC) begin
      width_clamped = ssa_pkg::SYNC_MIN_CYC;
    end else if (sync_pulse_width_setting > ssa_pkg::SYNC_MAX_CYC) begin
      width_clamped = ssa_pkg::SYNC_MAX_CYC;
    end else begin
      width_clamped = sync_pulse_width_setting;
    end
  end

  // restart once per period, or also at mid-period in double update
  assign start = pwm_period_start | (double_update & pwm_half_start);

  // pulse stays high for exactly width_clamped cycles
  always_comb begin
    st_nxt = st_r;
    if (start) begin
      st_nxt.remain = width_clamped - 1'b1;
      st_nxt.pulse  = 1'b1;
    end else if (st_r.remain != '0) begin
      st_nxt.remain = st_r.remain - 1'b1;
    end else begin
      st_nxt.pulse = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pwm_cycle_sync_pulse = st_r.pulse;
endmodule

// >>> src/ssa_top.sv
`timescale 1ns/1ns
// Behaviour
// - four comparators share one conversion counter, one comparator per channel.
// - all four channels convert at the same time within one window.
// - time from ramp start to crossing is held in a 12-bit counter.
// - each channel's trip captures the counter; it moves into that channel's result register at the next sync pulse.
// - each sync pulse discharges the ramp and restarts counting from zero.
// - the sync pulse width comes from a programmable setting, 0.05 to 12.5 us.
// - channel four goes through a 4-to-1 mux selected by two mode bits, 11 = calibration.
// - one mux input is the internal reference for ramp slope calibration.
// - mode bit 7 clear counts at input clock rate, set counts at core clock rate.
// - the count never exceeds 4095 and otherwise ends with the window.
// - double update restarts the window each half period, single once per period.
// - a channel that never trips in a window reports zero.
// - the ramp current is chosen from eight steps by software.
// - the current trim is a 3-bit field, 0 minimum, 7 maximum, reset to 0.
module ssa_top (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [7:0]                  paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic                        pwm_period_start,
  input  wire logic                        pwm_half_start,
  input  wire logic [ssa_pkg::NCH-1:0]     comp_trip,
  output logic                             pwm_cycle_sync_pulse,
  output logic                             ramp_discharge,
  output logic                             aux_select_high_bit,
  output logic                             aux_select_low_bit,
  output logic [ssa_pkg::TRIM_W-1:0]       ramp_current_trim
);
  typedef logic [ssa_pkg::CNT_W-1:0] ssa_cnt_t;

  typedef struct packed {
    ssa_cnt_t                        count;
    logic                            half_phase;
    logic                            sync_prev;
    logic [ssa_pkg::NCH-1:0]         trip_prev;
    logic [ssa_pkg::NCH-1:0]         tripped;
    logic [ssa_pkg::NCH-1:0][11:0]   cap;
    logic [ssa_pkg::NCH-1:0][11:0]   result;
    logic [1:0]                      aux_sel;
    logic                            count_rate_select;
    logic                            double_update;
    logic [ssa_pkg::WIDTH_W-1:0]     width;
    logic [ssa_pkg::TRIM_W-1:0]      trim;
    logic                            discharge;
    logic [31:0]                     rdata;
    logic                            ready;
    logic                            err;
  } ssa_top_st_t;

  ssa_top_st_t             st_r;
  ssa_top_st_t             st_nxt;
  logic [ssa_pkg::NCH-1:0] trip_sync;
  logic [ssa_pkg::NCH-1:0] trip_rise;
  logic                    sync_pulse;
  logic                    tick;
  logic                    window_end;
  logic                    setup;
  logic                    wr_commit;
  logic                    mapped;
  logic [31:0]             rd_mux;

  //////////////////////////////////////////////////////////////////////////
  // comparator inputs cross into pclk
  ssa_sync2 #(
    .W (ssa_pkg::NCH)
  ) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (comp_trip),
    .q       (trip_sync)
  );

  // conversion start pulse
  ssa_sync_gen u_gen (
    .pclk                     (pclk),
    .presetn                  (presetn),
    .pwm_period_start         (pwm_period_start),
    .pwm_half_start           (pwm_half_start),
    .double_update            (st_r.double_update),
    .sync_pulse_width_setting (st_r.width),
    .pwm_cycle_sync_pulse     (sync_pulse)
  );

  //////////////////////////////////////////////////////////////////////////
  // per-channel rising edge of the synchronised comparator
  for (genvar i = 0; i < ssa_pkg::NCH; i++) begin : g_edge
    assign trip_rise[i] = trip_sync[i] & ~st_r.trip_prev[i];
  end

  // input clock rate ticks every other pclk, core rate every pclk
  assign tick       = st_r.count_rate_select | st_r.half_phase;
  assign window_end = sync_pulse & ~st_r.sync_prev;

  //////////////////////////////////////////////////////////////////////////
  // apb decode
  assign setup     = psel & ~penable;
  assign wr_commit = psel & penable & pwrite & st_r.ready;

  always_comb begin
    mapped = 1'b1;
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      ssa_pkg::OFS_MODE: begin
        rd_mux[ssa_pkg::BIT_AUX_LO] = st_r.aux_sel[0];
        rd_mux[ssa_pkg::BIT_AUX_HI] = st_r.aux_sel[1];
        rd_mux[ssa_pkg::BIT_RATE]   = st_r.count_rate_select;
        rd_mux[ssa_pkg::BIT_DOUBLE] = st_r.double_update;
      end
      ssa_pkg::OFS_WIDTH:  rd_mux[ssa_pkg::WIDTH_W-1:0] = st_r.width;
      ssa_pkg::OFS_TRIM:   rd_mux[ssa_pkg::TRIM_W-1:0]  = st_r.trim;
      ssa_pkg::OFS_RES1:   rd_mux[11:0] = st_r.result[0];
      ssa_pkg::OFS_RES2:   rd_mux[11:0] = st_r.result[1];
      ssa_pkg::OFS_RES3:   rd_mux[11:0] = st_r.result[2];
      ssa_pkg::OFS_RESAUX: rd_mux[11:0] = st_r.result[3];
      ssa_pkg::OFS_STATUS: begin
        rd_mux[11:0]                  = st_r.count;
        rd_mux[ssa_pkg::BIT_ST_WIN]   = ~sync_pulse;
        rd_mux[ssa_pkg::BIT_ST_TRIP +: ssa_pkg::NCH] = st_r.tripped;
      end
      default: mapped = 1'b0;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    st_nxt           = st_r;
    st_nxt.sync_prev = sync_pulse;
    st_nxt.trip_prev = trip_sync;
    st_nxt.discharge = sync_pulse;

    // shared counter: zero during pulse, counts after, saturates
    if (sync_pulse) begin
      st_nxt.count      = '0;
      st_nxt.half_phase = 1'b0;
    end else begin
      st_nxt.half_phase = ~st_r.half_phase;
      if (tick && st_r.count != ssa_pkg::CNT_LIMIT) begin
        st_nxt.count = st_r.count + 1'b1;
      end
    end

    // all channels captured in parallel against one count
    for (int c = 0; c < ssa_pkg::NCH; c++) begin
      if (window_end) begin
        st_nxt.result[c]  = st_r.tripped[c] ? st_r.cap[c] : 12'h000;
        st_nxt.tripped[c] = 1'b0;
      end else if (!sync_pulse && trip_rise[c] && !st_r.tripped[c]) begin
        st_nxt.cap[c]     = st_r.count;
        st_nxt.tripped[c] = 1'b1;
      end
    end

    // apb: no wait cycle, ready in the first access cycle, read data registered in setup
    st_nxt.ready = setup & ~st_r.ready;
    st_nxt.err   = setup & ~st_r.ready & ~mapped; // error flag stands with ready only
    if (setup) begin
      st_nxt.rdata = pwrite ? 32'h0000_0000 : rd_mux;
    end else if (!psel) begin
      st_nxt.rdata = 32'h0000_0000;
    end

    // register writes
    if (wr_commit && !st_r.err) begin
      unique case (paddr)
        ssa_pkg::OFS_MODE: begin
          st_nxt.aux_sel[0]        = pwdata[ssa_pkg::BIT_AUX_LO];
          st_nxt.aux_sel[1]        = pwdata[ssa_pkg::BIT_AUX_HI];
          st_nxt.count_rate_select = pwdata[ssa_pkg::BIT_RATE];
          st_nxt.double_update     = pwdata[ssa_pkg::BIT_DOUBLE];
        end
        ssa_pkg::OFS_WIDTH: st_nxt.width = pwdata[ssa_pkg::WIDTH_W-1:0];
        ssa_pkg::OFS_TRIM:  st_nxt.trim  = pwdata[ssa_pkg::TRIM_W-1:0];
        default: ;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r                   <= '0;
      st_r.aux_sel           <= ssa_pkg::RST_AUX_SEL;
      st_r.count_rate_select <= ssa_pkg::RST_RATE;
      st_r.double_update     <= ssa_pkg::RST_DOUBLE;
      st_r.width             <= ssa_pkg::RST_WIDTH;
      st_r.trim              <= ssa_pkg::RST_TRIM;
    end else begin
      st_r <= st_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs, all from flops
  assign prdata               = st_r.rdata;
  assign pready               = st_r.ready;
  assign pslverr              = st_r.err;
  assign pwm_cycle_sync_pulse = sync_pulse;
  assign ramp_discharge       = st_r.discharge;
  assign aux_select_high_bit  = st_r.aux_sel[1];
  assign aux_select_low_bit   = st_r.aux_sel[0];
  assign ramp_current_trim    = st_r.trim;
endmodule

// >>> sim/ssa_top_asserts.sv
`timescale 1ns/1ns
// port-level checks of the register bus and the conversion timing
module ssa_top_asserts (
  input wire logic                        pclk,
  input wire logic                        presetn,
  input wire logic                        psel,
  input wire logic                        penable,
  input wire logic                        pwrite,
  input wire logic [7:0]                  paddr,
  input wire logic [31:0]                 pwdata,
  input wire logic [31:0]                 prdata,
  input wire logic                        pready,
  input wire logic                        pslverr,
  input wire logic                        pwm_period_start,
  input wire logic                        pwm_half_start,
  input wire logic                        pwm_cycle_sync_pulse,
  input wire logic                        ramp_discharge,
  input wire logic                        aux_select_high_bit,
  input wire logic                        aux_select_low_bit,
  input wire logic [ssa_pkg::TRIM_W-1:0]  ramp_current_trim
);
  logic       wr_go;
  logic [9:0] wid_r;
  logic [9:0] hi_r;
  logic [9:0] wid_c;
  logic [9:0] md_r;
  logic [2:0] tr_r;
  // committed write and clamped pulse width
  assign wr_go = psel && penable && pready && pwrite;
  assign wid_c = (wid_r < 10'h003) ? 10'h003 : ((wid_r > 10'h271) ? 10'h271 : wid_r);
  // shadow of written settings, length of the current sync pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wid_r <= ssa_pkg::RST_WIDTH;
      md_r  <= 10'h000;
      tr_r  <= 3'h0;
      hi_r  <= 10'h000;
    end else begin
      if (wr_go && paddr == ssa_pkg::OFS_WIDTH) wid_r <= pwdata[9:0];
      if (wr_go && paddr == ssa_pkg::OFS_MODE) md_r <= pwdata[9:0];
      if (wr_go && paddr == ssa_pkg::OFS_TRIM) tr_r <= pwdata[2:0];
      hi_r <= pwm_cycle_sync_pulse ? hi_r + 10'h001 : 10'h000;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sync_width_a: assert property ($fell(pwm_cycle_sync_pulse) |-> hi_r == wid_c)
    else $error("sync pulse width wrong");
  sync_start_a: assert property (
    pwm_period_start && !pwm_cycle_sync_pulse |=> pwm_cycle_sync_pulse)
    else $error("sync pulse missing after period start");
  half_start_a: assert property (
    pwm_half_start && md_r[9] && !pwm_cycle_sync_pulse |=> pwm_cycle_sync_pulse)
    else $error("sync pulse missing after half start");
  no_spurious_a: assert property (
    $rose(pwm_cycle_sync_pulse) |->
      $past(pwm_period_start) || ($past(pwm_half_start) && md_r[9]))
    else $error("sync pulse without start");
  ramp_discharge_a: assert property (ramp_discharge == $past(pwm_cycle_sync_pulse))
    else $error("ramp discharge does not follow sync");
  aux_select_a: assert property (
    {aux_select_high_bit, aux_select_low_bit} == md_r[1:0])
    else $error("aux select differs from mode");
  trim_value_a: assert property (ramp_current_trim == tr_r)
    else $error("trim output differs from written value");
  ready_pulse_a: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("ready not a single cycle after setup");
  unmapped_err_a: assert property (
    pready && paddr > ssa_pkg::OFS_STATUS |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
endmodule
bind ssa_top ssa_top_asserts chk (
  .pclk                 (pclk),
  .presetn              (presetn),
  .psel                 (psel),
  .penable              (penable),
  .pwrite               (pwrite),
  .paddr                (paddr),
  .pwdata               (pwdata),
  .prdata               (prdata),
  .pready               (pready),
  .pslverr              (pslverr),
  .pwm_period_start     (pwm_period_start),
  .pwm_half_start       (pwm_half_start),
  .pwm_cycle_sync_pulse (pwm_cycle_sync_pulse),
  .ramp_discharge       (ramp_discharge),
  .aux_select_high_bit  (aux_select_high_bit),
  .aux_select_low_bit   (aux_select_low_bit),
  .ramp_current_trim    (ramp_current_trim)
);

// >>> sim/ssa_far_model.sv
`timescale 1ns/1ns
// ramp and comparators: trip once the ramp age reaches each threshold
module ssa_far_model (
  input  wire logic             pclk,
  input  wire logic             ramp_discharge,
  input  wire logic [3:0][15:0] thr,
  output logic      [3:0]       comp_trip
);
  logic [15:0] age_r = 16'h0000;
  // ramp held at zero while discharged, rising otherwise
  always @(posedge pclk) begin
    if (ramp_discharge) age_r <= 16'h0000;
    else if (age_r != 16'hfffe) age_r <= age_r + 16'h0001;
  end
  // comparator levels, low while the capacitor is shorted
  always_comb begin
    for (int i = 0; i < 4; i++) comp_trip[i] = !ramp_discharge && (age_r >= thr[i]);
  end
endmodule

// >>> sim/single_slope_adc_timer_bench.sv
`timescale 1ns/1ns
module single_slope_adc_timer_bench;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pstart = 0, phalf = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, sync, disch, a_hi, a_lo, e;
  logic [2:0] trim;
  logic [3:0] trip;
  logic [3:0][15:0] thr = '1;
  int n_mismatch = 0, n_checks = 0;
  ////////////////////////////////////////////////////////////////////
  // clock, design and far side
  always #10 pclk = ~pclk;
  ssa_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pwm_period_start(pstart), .pwm_half_start(phalf), .comp_trip(trip),
    .pwm_cycle_sync_pulse(sync), .ramp_discharge(disch), .aux_select_high_bit(a_hi),
    .aux_select_low_bit(a_lo), .ramp_current_trim(trim));
  ssa_far_model far (.pclk(pclk), .ramp_discharge(disch), .thr(thr), .comp_trip(trip));
  ////////////////////////////////////////////////////////////////////
  // compare, bus and pulse helpers
  task chk(input logic [31:0] g, input logic [31:0] x);
    n_checks++;
    if (g !== x) begin
      n_mismatch++;
      $display("wrong value t=%0t got %h exp %h", $time, g, x);
    end
  endtask
  task chkr(input logic [31:0] g, input logic [31:0] lo, input logic [31:0] hi);
    n_checks++;
    if ((g >= lo && g <= hi) !== 1'b1) begin
      n_mismatch++;
      $display("wrong value t=%0t got %h exp %h..%h", $time, g, lo, hi);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) n_mismatch++;
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task pulse(input logic half);
    @(posedge pclk);
    if (half) phalf <= 1'b1;
    else pstart <= 1'b1;
    @(posedge pclk);
    phalf  <= 1'b0;
    pstart <= 1'b0;
  endtask
  // cycles for which the sync pulse still stands, bounded
  task sync_len(output int n);
    n = 0;
    @(negedge pclk);
    while (sync === 1'b1 && n < 1000) begin
      n++;
      @(negedge pclk);
    end
  endtask
  ////////////////////////////////////////////////////////////////////
  // reset values, trim range, aux codes, unmapped address
  task t_regs;
    apb(0, ssa_pkg::OFS_MODE, 0);
    chk(r, 32'h0);
    apb(0, ssa_pkg::OFS_WIDTH, 0);
    chk(r, 32'h64);
    apb(0, ssa_pkg::OFS_TRIM, 0);
    chk(r, 32'h0);
    apb(0, ssa_pkg::OFS_RES1, 0);
    chk(r, 32'h0);
    apb(0, 8'h20, 0);
    chk({31'h0, e}, 32'h1);
    chk(r, 32'h0);
    for (int i = 0; i < 8; i++) begin
      apb(1, ssa_pkg::OFS_TRIM, i);
      apb(0, ssa_pkg::OFS_TRIM, 0);
      chk(r, i);
      chk({29'h0, trim}, i);
    end
    for (int i = 0; i < 4; i++) begin
      apb(1, ssa_pkg::OFS_MODE, i);
      @(negedge pclk);
      chk({30'h0, a_hi, a_lo}, i);
    end
  endtask
  // width clamped at both ends, counter held at zero in the pulse
  task t_width;
    int n;
    apb(1, ssa_pkg::OFS_WIDTH, 32'h1);
    apb(0, ssa_pkg::OFS_WIDTH, 0);
    chk(r, 32'h1);
    pulse(0);
    sync_len(n);
    chk(n, 32'h3);
    apb(1, ssa_pkg::OFS_WIDTH, 32'h3ff);
    pulse(0);
    sync_len(n);
    chk(n, 32'h271);
    apb(1, ssa_pkg::OFS_WIDTH, 32'h64);
    pulse(0);
    apb(0, ssa_pkg::OFS_STATUS, 0);
    chk(r, 32'h0);
    sync_len(n);
    apb(0, ssa_pkg::OFS_STATUS, 0);
    chk({31'h0, r[ssa_pkg::BIT_ST_WIN]}, 32'h1);
  endtask
  // one window with thresholds, results read after the next start
  task t_conv(input logic fast);
    logic [15:0] t;
    int          n;
    apb(1, ssa_pkg::OFS_MODE, {fast, 7'h00});
    thr <= {fast ? 16'hffff : 16'h0064, 16'h00c8, 16'h003c, 16'h0014};
    pulse(0);
    repeat (400) @(posedge pclk);
    pulse(0);
    repeat (5) @(posedge pclk);
    for (int i = 0; i < 4; i++) begin
      t = thr[i];
      apb(0, ssa_pkg::OFS_RES1 + 8'(4 * i), 0);
      if (t == 16'hffff) chk(r, 32'h0);
      else if (fast) chkr(r, t, t + 8);
      else chkr(r, t / 2, t / 2 + 5);
    end
    // let the pulse end before the next start
    sync_len(n);
  endtask
  // half-period start honoured in double update only
  task t_dbl;
    int n;
    apb(1, ssa_pkg::OFS_MODE, 32'h200);
    pulse(1);
    @(negedge pclk);
    chk({31'h0, sync}, 32'h1);
    sync_len(n);
    apb(1, ssa_pkg::OFS_MODE, 0);
    pulse(1);
    @(negedge pclk);
    chk({31'h0, sync}, 32'h0);
  endtask
  ////////////////////////////////////////////////////////////////////
  task stop_test;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1;
    t_regs;
    t_width;
    t_conv(0);
    t_conv(1);
    t_dbl;
    stop_test;
  end
  // watchdog
  initial begin
    repeat (10000) @(posedge pclk);
    n_mismatch++;
    stop_test;
  end
endmodule
